// [verilog/light_prox_irq.v]
`timescale 1ns/10ps
`default_nettype none
`include "light_prox_consts.vh"

module light_prox_irq
#(
  parameter AW           = 8,
  parameter AMB_PERIOD   = `AMB_PERIOD_MS * (`CLK_FREQ_HZ / 1000),
  parameter PROX_STEP    = `PROX_STEP_MS * (`CLK_FREQ_HZ / 1000)
)
(
  // clock, reset, enable
  input  wire          core_clk,
  input  wire          resetn,
  input  wire          ce,
  // axi4-lite write
  input  wire [AW-1:0] awaddr,
  input  wire          awvalid,
  output reg           awready,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output reg           wready,
  output reg  [1:0]    bresp,
  output reg           bvalid,
  input  wire          bready,
  // axi4-lite read
  input  wire [AW-1:0] araddr,
  input  wire          arvalid,
  output reg           arready,
  output reg  [31:0]   rdata,
  output reg  [1:0]    rresp,
  output reg           rvalid,
  input  wire          rready,
  // converters
  output reg           ambientStart,
  input  wire          ambientDone,
  input  wire [11:0]   ambientResult,
  output reg           proxStart,
  input  wire          proxDone,
  input  wire [7:0]    proxResult,
  // converter controls
  output reg           powerDown,
  output reg           luxRangeSelect,
  output reg           visibleOrInfraredSelect,
  output reg           ledDriveHigh,
  // pins and interrupts
  input  wire          busAddressSelectPin,
  output reg           intN,
  output reg           irq
);

  reg  [AW-1:0] awaddrHeld;
  reg  [7:0]    wdataHeld;
  reg           wstrbHeld;
  reg  [7:0]    cfg1;
  reg  [7:0]    cfg2;
  reg  [7:0]    proxLow;
  reg  [7:0]    proxHigh;
  reg  [7:0]    ambThrA;
  reg  [7:0]    ambThrB;
  reg  [7:0]    ambThrC;
  reg  [7:0]    test1;
  reg  [7:0]    test2;
  reg  [7:0]    proxData;
  reg  [11:0]   ambData;
  reg           ambFlag;
  reg           proxFlag;
  reg  [1:0]    irqStatus;
  reg  [1:0]    irqMask;
  reg           pinMeta;
  reg           pinSync;
  reg  [31:0]   rdMux;
  reg           rdHit;
  reg           wrHit;

  wire [5:0]  wrIdx     = awaddrHeld[7:2];
  wire [5:0]  rdIdx     = araddr[7:2];
  wire        doWrite   = ~awready & ~wready & ~bvalid;
  wire        wrEn      = doWrite & wrHit & wstrbHeld;
  wire        ambHit;
  wire        proxHit;
  wire        ambTick;
  wire        proxTick;
  wire        ambEn     = cfg1[`C1_AMB_EN];
  wire        proxEn    = cfg1[`C1_PROX_EN];
  wire [3:0]  sleepMul  = `SLEEP_STEPS -
                          {1'b0, cfg1[`C1_SLEEP_HI:`C1_SLEEP_LO]};
  wire [31:0] proxLimit = PROX_STEP * sleepMul;
  wire [31:0] ambLimit  = AMB_PERIOD;
  wire        wrCfg2    = wrEn & (wrIdx == `IDX_CFG2);
  wire        wrStatus  = wrEn & (wrIdx == `IDX_IRQ_STATUS);

  // a written one keeps the flag
  wire next_ambFlag  = ambHit |
                       (ambFlag & ~(wrCfg2 & ~wdataHeld[`C2_AMB_FLAG]));
  wire next_proxFlag = proxHit |
                       (proxFlag & ~(wrCfg2 & ~wdataHeld[`C2_PROX_FLAG]));
  wire [1:0] next_irqStatus = {proxHit, ambHit} |
                              (irqStatus & ~({2{wrStatus}} & wdataHeld[1:0]));

  // combine bit one needs both flags
  // either flag when combine bit zero
  wire next_intActive = cfg2[`C2_COMBINE] ? (next_ambFlag & next_proxFlag)
                                          : (next_ambFlag | next_proxFlag);

  period_timer #(.CW(32)) ambTimer
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .run      (ambEn),
    .limit    (ambLimit),
    .tick     (ambTick)
  );

  period_timer #(.CW(32)) proxTimer
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .run      (proxEn),
    .limit    (proxLimit),
    .tick     (proxTick)
  );

  window_persist #(.W(12)) ambWindow
  (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .ce          (ce),
    .enable      (ambEn),
    .sample      (ambientDone),
    .data        (ambientResult),
    .lowThr      ({ambThrB[3:0], ambThrA}),
    .highThr     ({ambThrC, ambThrB[7:4]}),
    .persistCode (cfg2[`C2_APERS_HI:`C2_APERS_LO]),
    .hit         (ambHit)
  );

  window_persist #(.W(8)) proxWindow
  (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .ce          (ce),
    .enable      (proxEn),
    .sample      (proxDone),
    .data        (proxResult),
    .lowThr      (proxLow),
    .highThr     (proxHigh),
    .persistCode (cfg2[`C2_PPERS_HI:`C2_PPERS_LO]),
    .hit         (proxHit)
  );

  always @*
  begin
    wrHit = 1'b1;
    case (wrIdx)
      `IDX_CFG1, `IDX_CFG2, `IDX_PROX_LOW, `IDX_PROX_HIGH,
      `IDX_AMB_THR_A, `IDX_AMB_THR_B, `IDX_AMB_THR_C,
      `IDX_PROX_DATA, `IDX_AMB_DATA_LO, `IDX_AMB_DATA_HI,
      `IDX_TEST1, `IDX_TEST2, `IDX_IRQ_STATUS, `IDX_IRQ_MASK,
      `IDX_BUS_ADDR: wrHit = 1'b1;
      default:       wrHit = 1'b0;
    endcase
  end

  always @*
  begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (rdIdx)
      `IDX_CFG1:        rdMux[7:0] = cfg1;
      `IDX_CFG2:        rdMux[7:0] = {proxFlag, cfg2[6:4], ambFlag,
                                      cfg2[2:0]};
      `IDX_PROX_LOW:    rdMux[7:0] = proxLow;
      `IDX_PROX_HIGH:   rdMux[7:0] = proxHigh;
      `IDX_AMB_THR_A:   rdMux[7:0] = ambThrA;
      `IDX_AMB_THR_B:   rdMux[7:0] = ambThrB;
      `IDX_AMB_THR_C:   rdMux[7:0] = ambThrC;
      `IDX_PROX_DATA:   rdMux[7:0] = proxData;
      `IDX_AMB_DATA_LO: rdMux[7:0] = ambData[7:0];
      `IDX_AMB_DATA_HI: rdMux[3:0] = ambData[11:8];
      `IDX_TEST1:       rdMux[7:0] = test1;
      `IDX_TEST2:       rdMux[7:0] = test2;
      `IDX_IRQ_STATUS:  rdMux[1:0] = irqStatus;
      `IDX_IRQ_MASK:    rdMux[1:0] = irqMask;
      // fixed upper bits, pin as lsb
      `IDX_BUS_ADDR:    rdMux[6:0] = {`BUS_ADDR_UPPER, pinSync};
      default:          rdHit      = 1'b0;
    endcase
  end

  // bus slave, one write and one read at a time
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      arready    <= 1'b1;
      rvalid     <= 1'b0;
      rresp      <= `RESP_OKAY;
      rdata      <= 32'h00000000;
      awaddrHeld <= {AW{1'b0}};
      wdataHeld  <= 8'h00;
      wstrbHeld  <= 1'b0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awaddrHeld <= awaddr;
        awready    <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wdataHeld <= wdata[7:0];
        wstrbHeld <= wstrb[0];
        wready    <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rdMux;
        rresp   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // registers, flags and pin
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg1      <= `RST_CFG1;
      cfg2      <= `RST_CFG2;
      proxLow   <= `RST_PROX_LOW;
      proxHigh  <= `RST_PROX_HIGH;
      ambThrA   <= `RST_AMB_THR_A;
      ambThrB   <= `RST_AMB_THR_B;
      ambThrC   <= `RST_AMB_THR_C;
      test1     <= `RST_TEST;
      test2     <= `RST_TEST;
      proxData  <= 8'h00;
      ambData   <= 12'h000;
      ambFlag   <= 1'b0;
      proxFlag  <= 1'b0;
      irqStatus <= `RST_IRQ;
      irqMask   <= `RST_IRQ;
      pinMeta   <= 1'b0;
      pinSync   <= 1'b0;
      intN      <= 1'b1;
      irq       <= 1'b0;
      powerDown <= 1'b1;
      luxRangeSelect          <= 1'b0;
      visibleOrInfraredSelect <= 1'b0;
      ledDriveHigh            <= 1'b0;
      ambientStart            <= 1'b0;
      proxStart               <= 1'b0;
    end
    else if (ce)
    begin
      pinMeta <= busAddressSelectPin;
      pinSync <= pinMeta;
      if (wrEn)
      begin
        case (wrIdx)
          `IDX_CFG1:       cfg1     <= wdataHeld;
          `IDX_CFG2:       cfg2     <= wdataHeld;
          `IDX_PROX_LOW:   proxLow  <= wdataHeld;
          `IDX_PROX_HIGH:  proxHigh <= wdataHeld;
          `IDX_AMB_THR_A:  ambThrA  <= wdataHeld;
          `IDX_AMB_THR_B:  ambThrB  <= wdataHeld;
          `IDX_AMB_THR_C:  ambThrC  <= wdataHeld;
          `IDX_TEST1:      test1    <= wdataHeld;
          `IDX_TEST2:      test2    <= wdataHeld;
          `IDX_IRQ_MASK:   irqMask  <= wdataHeld[1:0];
          default:         cfg1     <= cfg1;
        endcase
      end
      if (ambientDone)
        ambData <= ambientResult;
      if (proxDone)
        proxData <= proxResult;
      ambFlag   <= next_ambFlag;
      proxFlag  <= next_proxFlag;
      irqStatus <= next_irqStatus;
      irq       <= |(next_irqStatus & irqMask);
      intN      <= ~next_intActive;
      powerDown <= ~ambEn & ~proxEn;
      luxRangeSelect          <= cfg1[`C1_RANGE];
      visibleOrInfraredSelect <= cfg1[`C1_IR_MODE];
      ledDriveHigh            <= cfg1[`C1_DRIVE];
      ambientStart            <= ambTick;
      proxStart               <= proxTick;
    end
  end

endmodule

`default_nettype wire

// [verilog/light_prox_consts.vh]
`ifndef LIGHT_PROX_CONSTS_VH
`define LIGHT_PROX_CONSTS_VH

// register indices, byte address is index times four
`define IDX_CFG1        6'h01
`define IDX_CFG2        6'h02
`define IDX_PROX_LOW    6'h03
`define IDX_PROX_HIGH   6'h04
`define IDX_AMB_THR_A   6'h05
`define IDX_AMB_THR_B   6'h06
`define IDX_AMB_THR_C   6'h07
`define IDX_PROX_DATA   6'h08
`define IDX_AMB_DATA_LO 6'h09
`define IDX_AMB_DATA_HI 6'h0A
`define IDX_TEST1       6'h0E
`define IDX_TEST2       6'h0F
`define IDX_IRQ_STATUS  6'h10
`define IDX_IRQ_MASK    6'h11
`define IDX_BUS_ADDR    6'h12

// reset values
`define RST_CFG1        8'h00
`define RST_CFG2        8'h00
`define RST_PROX_LOW    8'h00
`define RST_PROX_HIGH   8'hFF
`define RST_AMB_THR_A   8'h00
`define RST_AMB_THR_B   8'hF0
`define RST_AMB_THR_C   8'hFF
`define RST_TEST        8'h00
`define RST_IRQ         2'h0

// configuration 1 fields
`define C1_PROX_EN      7
`define C1_SLEEP_HI     6
`define C1_SLEEP_LO     4
`define C1_DRIVE        3
`define C1_AMB_EN       2
`define C1_RANGE        1
`define C1_IR_MODE      0

// configuration 2 fields
`define C2_PROX_FLAG    7
`define C2_PPERS_HI     6
`define C2_PPERS_LO     5
`define C2_AMB_FLAG     3
`define C2_APERS_HI     2
`define C2_APERS_LO     1
`define C2_COMBINE      0

// interrupt status and mask bits
`define IRQ_AMB         0
`define IRQ_PROX        1

// persistency codes to consecutive counts
`define PERSIST_0       5'h01
`define PERSIST_1       5'h04
`define PERSIST_2       5'h08
`define PERSIST_3       5'h10

// bus target address, upper six bits
`define BUS_ADDR_UPPER  6'h22

// timing
`define CLK_FREQ_HZ     100000000
`define AMB_PERIOD_MS   100
`define PROX_STEP_MS    100
`define SLEEP_STEPS     4'h8

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [verilog/period_timer.v]
`timescale 1ns/10ps
`default_nettype none

module period_timer
#(
  parameter CW = 32
)
(
  // clock and reset
  input  wire          core_clk,
  input  wire          resetn,
  input  wire          ce,
  // control
  input  wire          run,
  input  wire [CW-1:0] limit,
  // pulse each period
  output reg           tick
);

  reg [CW-1:0] count;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= {CW{1'b0}};
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      if (!run)
        count <= {CW{1'b0}};
      else if (count >= limit - {{(CW-1){1'b0}}, 1'b1})
      begin
        count <= {CW{1'b0}};
        tick  <= 1'b1;
      end
      else
        count <= count + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// [verilog/window_persist.v]
`timescale 1ns/10ps
`default_nettype none
`include "light_prox_consts.vh"

module window_persist
#(
  parameter W = 12
)
(
  // clock and reset
  input  wire         core_clk,
  input  wire         resetn,
  input  wire         ce,
  // sample
  input  wire         enable,
  input  wire         sample,
  input  wire [W-1:0] data,
  // window and persistency
  input  wire [W-1:0] lowThr,
  input  wire [W-1:0] highThr,
  input  wire [1:0]   persistCode,
  // one-cycle pulse when the run is long enough
  output reg          hit
);

  reg  [4:0] runCount;
  reg  [4:0] need;
  wire [4:0] nextRun = runCount + 5'h01;
  wire       outside = (data < lowThr) || (data > highThr);

  always @*
  begin
    case (persistCode)
      2'h0:    need = `PERSIST_0;
      2'h1:    need = `PERSIST_1;
      2'h2:    need = `PERSIST_2;
      default: need = `PERSIST_3;
    endcase
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      runCount <= 5'h00;
      hit      <= 1'b0;
    end
    else if (ce)
    begin
      hit <= 1'b0;
      if (!enable)
        runCount <= 5'h00;
      else if (sample)
      begin
        if (!outside)
          runCount <= 5'h00;
        else if (nextRun >= need)
        begin
          runCount <= need;
          hit      <= 1'b1;
        end
        else
          runCount <= nextRun;
      end
    end
  end

endmodule

`default_nettype wire

// [tb/light_prox_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module light_prox_chk (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // register bus
  input  wire logic        awready,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [1:0]  bresp,
  input  wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] rdata,
  // converters and pins
  input  wire logic        ambientStart,
  input  wire logic        ambientDone,
  input  wire logic        proxStart,
  input  wire logic        proxDone,
  input  wire logic        powerDown,
  input  wire logic        intN,
  input  wire logic        irq
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

  property p_b_refuse;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken early");

  property p_b_release;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_release: assert property (p_b_release) else $error("bus not freed");

  property p_int_fall;
    $fell(intN) |-> $past(ambientDone, 2) || $past(proxDone, 2) || bvalid ||
                    $past(bvalid);
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("pin fell untimely");

  property p_int_rise;
    $rose(intN) |-> bvalid || $past(bvalid);
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("pin freed untimely");

  property p_irq_rise;
    $rose(irq) |-> $past(ambientDone, 2) || $past(proxDone, 2) || bvalid ||
                   $past(bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose untimely");

  property p_irq_fall;
    $fell(irq) |-> bvalid || $past(bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell untimely");

  property p_pd_quiet;
    powerDown [*3] |-> !ambientStart && !proxStart;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("start in power-down");

  c_int: cover property ($fell(intN));
  c_irq: cover property ($fell(irq));
  c_err: cover property (bvalid && bresp == 2'h2);
endmodule
bind light_prox_irq light_prox_chk chk_u (.core_clk, .resetn, .awready, .wready,
  .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .ambientStart,
  .ambientDone, .proxStart, .proxDone, .powerDown, .intN, .irq);
`default_nettype wire

// [tb/converter_model.sv]
`timescale 1ns/10ps
`default_nettype none
module converter_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // requests and values to report
  input  wire logic        ambientStart,
  input  wire logic        proxStart,
  input  wire logic [11:0] ambValue,
  input  wire logic [7:0]  proxValue,
  // results
  output var  logic        ambientDone,
  output var  logic [11:0] ambientResult,
  output var  logic        proxDone,
  output var  logic [7:0]  proxResult
);
  logic [1:0] ambBusy;
  logic [1:0] proxBusy;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ambBusy <= 2'h0;
      proxBusy <= 2'h0;
      ambientDone <= 1'b0;
      proxDone <= 1'b0;
      ambientResult <= 12'h000;
      proxResult <= 8'h00;
    end
    else
    begin
      ambBusy <= ambientStart ? 2'h2 : ambBusy - {1'b0, |ambBusy};
      proxBusy <= proxStart ? 2'h2 : proxBusy - {1'b0, |proxBusy};
      ambientDone <= (ambBusy == 2'h1);
      proxDone <= (proxBusy == 2'h1);
      // results hold no meaning outside the done cycle
      ambientResult <= (ambBusy == 2'h1) ? ambValue : ~ambientResult;
      proxResult <= (proxBusy == 2'h1) ? proxValue : ~proxResult;
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        core_clk, resetn, awvalid, wvalid, bready, arvalid, rready, pin;
  logic [7:0]  awaddr, araddr, proxValue;
  logic [31:0] wdata;
  logic [11:0] ambValue, rv;
  logic        ce;
  wire         awready, wready, bvalid, arready, rvalid, ambientStart;
  wire         ambientDone, proxStart, proxDone, powerDown, luxRangeSelect;
  wire         intN, irq, visibleOrInfraredSelect, ledDriveHigh;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [11:0] ambientResult;
  wire  [7:0]  proxResult;
  integer      n_fail, num_checks, seed;
  logic [33:0] notes[$];

  light_prox_irq #(.AW(8), .AMB_PERIOD(20), .PROX_STEP(5)) dut_u (.core_clk,
    .resetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .ambientStart, .ambientDone,
    .ambientResult, .proxStart, .proxDone, .proxResult, .powerDown,
    .luxRangeSelect, .visibleOrInfraredSelect, .ledDriveHigh,
    .busAddressSelectPin(pin), .intN, .irq);
  converter_model conv_u (.core_clk, .resetn, .ambientStart, .proxStart,
    .ambValue, .proxValue, .ambientDone, .ambientResult, .proxDone,
    .proxResult);

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
  begin
    num_checks = num_checks + 1;
    if (seen !== want)
    begin
      n_fail = n_fail + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, want);
    end
  end
  endtask

  task close_out;
  begin
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = 2'h0);
    logic aw;
    logic w;
  begin
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge core_clk);
      if (aw && awready)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge core_clk);
    check({32'h0, bresp}, {32'h0, er});
    bready <= 1'b0;
    @(posedge core_clk);
  end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = 2'h0);
  begin
    notes.push_back({er, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge core_clk);
    while (!arready) @(posedge core_clk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge core_clk);
    rready <= 1'b0;
    @(posedge core_clk);
  end
  endtask

  task automatic dones(input integer n, input logic prox);
  begin
    while (n > 0)
    begin
      @(posedge core_clk);
      if (prox ? proxDone : ambientDone)
        n = n - 1;
    end
    repeat (3) @(posedge core_clk);
  end
  endtask

  always @(posedge core_clk)
    if (rvalid && rready && notes.size() > 0)
      check({rresp, rdata}, notes.pop_front());

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail = n_fail + 1;
    close_out;
  end

  initial
  begin
    {n_fail, num_checks, seed} = {32'h0, 32'h0, 32'h0A47};
    {resetn, awvalid, wvalid, bready, arvalid, rready, pin} = 7'h01;
    ce = 1'b1;
    {awaddr, araddr, wdata, proxValue, ambValue} = 68'h0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(8'h10, 8'hFF);
    rd(8'h18, 8'hF0);
    rd(8'h48, 8'h45);
    rd(8'hFC, 8'h00, 2'h2);
    wr(8'hFC, 8'h55, 2'h2);
    check(powerDown, 1);
    wr(8'h04, 8'h00);
    wr(8'h3C, 8'h29);
    wr(8'h38, 8'h00);
    wr(8'h3C, 8'h00);
    rd(8'h3C, 8'h00);
    pin <= 1'b0;
    wr(8'h04, 8'h0B);
    check(luxRangeSelect, 1);
    check(visibleOrInfraredSelect, 1);
    check(ledDriveHigh, 1);
    rd(8'h48, 8'h44);
    wr(8'h0C, 8'h10);
    wr(8'h10, 8'h80);
    wr(8'h44, 8'h02);
    wr(8'h08, 8'h20);
    proxValue <= 8'h81 + (8'h7E & $random(seed));
    wr(8'h04, 8'hF0);
    dones(3, 1'b1);
    check(intN, 1);
    dones(1, 1'b1);
    check(intN, 0);
    check(irq, 1);
    proxValue <= 8'h40;
    wr(8'h04, 8'h00);
    wr(8'h08, 8'hA0);
    rd(8'h08, 8'hA0);
    check(intN, 0);
    wr(8'h08, 8'h20);
    check(intN, 1);
    wr(8'h40, 8'h02);
    check(irq, 0);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h1C, 8'h80);
    wr(8'h08, 8'h01);
    rv = 12'h801 + (12'h3FF & $random(seed));
    ambValue <= rv;
    wr(8'h04, 8'h04);
    dones(1, 1'b0);
    check(intN, 1);
    rd(8'h24, rv[7:0]);
    rd(8'h28, {4'h0, rv[11:8]});
    // host moves to the high range on a large count
    if (rv > 12'h708)
      wr(8'h04, 8'h06);
    check(luxRangeSelect, 1);
    wr(8'h08, 8'h09);
    proxValue <= 8'hC0;
    wr(8'h04, 8'hF4);
    dones(1, 1'b1);
    check(intN, 0);
    wr(8'h04, 8'h00);
    repeat (5) @(posedge core_clk);
    check(powerDown, 1);
    // clock enable low freezes the pin synchroniser
    ce <= 1'b0;
    pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    ce <= 1'b1;
    rd(8'h48, 8'h44);
    rd(8'h48, 8'h45);
    close_out;
  end
endmodule
`default_nettype wire
